// ===== src/wwt_defines.svh
// Register offsets, field positions, reset values and keys of the watchdog
`ifndef WWT_DEFINES_SVH
`define WWT_DEFINES_SVH

`define WWT_OFF_MODE 8'h00
`define WWT_OFF_TIMEOUT 8'h04
`define WWT_OFF_FEED 8'h08
`define WWT_OFF_COUNT 8'h0c
`define WWT_OFF_WINDOW 8'h10
`define WWT_OFF_WARN 8'h14
`define WWT_OFF_INT_STATUS 8'h18
`define WWT_OFF_INT_MASK 8'h1c
`define WWT_OFF_RESET_FLAG 8'h20

`define WWT_TIMEOUT_RST 24'hffffff
`define WWT_TIMEOUT_MIN 24'h0000ff
`define WWT_WINDOW_RST 24'hffffff
`define WWT_WARN_RST 24'h000000
`define WWT_FEED_KEY1 8'haa
`define WWT_FEED_KEY2 8'h55
`define WWT_PRESCALE_LAST 2'h3

`define WWT_EV_TIMEOUT 0
`define WWT_EV_WARN 1
`define WWT_EV_FEED 2
`define WWT_EV_WINDOW 3
`define WWT_EV_N 4

`define WWT_RESP_OKAY 2'h0
`define WWT_RESP_SLVERR 2'h2

`endif

// ===== src/wwt_pkg.sv
// Types of the windowed watchdog
package wwt_pkg;

    // Mode register layout, bit 31 downward
    typedef struct packed {
        logic [25:0] unused;
        logic keep_in_deep_sleep;
        logic clk_sel;
        logic warn_en;
        logic window_en;
        logic reset_en;
        logic enable;
    } wwt_mode_t;

    typedef enum logic [0:0] {
        WWT_FEED_IDLE = 1'b0,
        WWT_FEED_ARMED = 1'b1
    } wwt_feed_state_t;

endpackage

// ===== src/wwt_windowed_watchdog.sv
// Windowed watchdog timer with AXI4-Lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "wwt_defines.svh"

// Behaviour
// - Timeout without reload resets the chip
// - Reload outside window is a fault
// - Warning interrupt at programmed count before timeout
// - Enable set only; cleared by reset/fault
// - Bad feed resets, or interrupts in interrupt mode
// - Flag records watchdog caused reset
// - 24-bit counter behind prescaler from tick clock
// - Period in steps of four ticks, at least 1024
// - Software selects tick clock source
// - Low-power oscillator may keep running in deep sleep
module wwt_windowed_watchdog (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Oscillator ticks and power state
    input wire logic internal_rc_osc,
    input wire logic dedicated_lowpower_osc,
    input wire logic deep_sleep,
    // Chip side outputs
    output logic chip_reset,
    output logic irq,
    output logic lowpower_osc_keep,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    wwt_pkg::wwt_mode_t mode;
    logic [23:0] timeout_val;
    logic [23:0] window_val;
    logic [23:0] warn_val;
    logic [23:0] count;
    logic [1:0] prescale;
    logic tick_prev;
    logic [`WWT_EV_N-1:0] int_status;
    logic [`WWT_EV_N-1:0] int_mask;
    logic reset_flag;
    wwt_pkg::wwt_feed_state_t feed_state;

    logic aw_got;
    logic w_got;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // ------------------------------------------------------------
    // Byte lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire wr_fire = aw_got && w_got && !s_axi_bvalid;
    wire sel_mode = wr_addr == `WWT_OFF_MODE;
    wire sel_timeout = wr_addr == `WWT_OFF_TIMEOUT;
    wire sel_feed = wr_addr == `WWT_OFF_FEED;
    wire sel_count = wr_addr == `WWT_OFF_COUNT;
    wire sel_window = wr_addr == `WWT_OFF_WINDOW;
    wire sel_warn = wr_addr == `WWT_OFF_WARN;
    wire sel_status = wr_addr == `WWT_OFF_INT_STATUS;
    wire sel_mask = wr_addr == `WWT_OFF_INT_MASK;
    wire sel_flag = wr_addr == `WWT_OFF_RESET_FLAG;
    wire wr_mapped = sel_mode || sel_timeout || sel_feed || sel_count ||
        sel_window || sel_warn || sel_status || sel_mask || sel_flag;

    wire [31:0] mode_merged = merge(32'(mode), wr_data, wr_strb);
    wire [31:0] timeout_merged = merge({8'h00, timeout_val}, wr_data,
        wr_strb);
    wire [31:0] window_merged = merge({8'h00, window_val}, wr_data,
        wr_strb);
    wire [31:0] warn_merged = merge({8'h00, warn_val}, wr_data, wr_strb);
    wire [31:0] mask_merged = merge({28'h0000000, int_mask}, wr_data,
        wr_strb);
    wire [31:0] w1c_bits = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
        {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // ------------------------------------------------------------
    // Feed sequence
    // ------------------------------------------------------------
    wire [7:0] feed_byte = wr_data[7:0];
    wire feed_lane = wr_strb[0];
    wire feed_wr = wr_fire && sel_feed && mode.enable;
    wire key1 = feed_lane && feed_byte == `WWT_FEED_KEY1;
    wire key2 = feed_lane && feed_byte == `WWT_FEED_KEY2;
    wire armed = feed_state == wwt_pkg::WWT_FEED_ARMED;
    wire feed_ok = feed_wr && armed && key2;
    // Any write other than the second key breaks an armed sequence
    wire feed_bad = mode.enable && wr_fire &&
        ((sel_feed && (armed ? !key2 : !key1)) ||
         (!sel_feed && armed));
    wire window_bad = feed_ok && mode.window_en &&
        count > window_val;

    // ------------------------------------------------------------
    // Tick clock and counter
    // ------------------------------------------------------------
    // Internal RC stops in deep sleep; low-power osc only if kept
    wire rc_live = internal_rc_osc && !deep_sleep;
    wire lp_live = dedicated_lowpower_osc &&
        (!deep_sleep || mode.keep_in_deep_sleep);
    wire watchdog_tick_clock = mode.clk_sel ? lp_live : rc_live;
    wire tick_edge = watchdog_tick_clock && !tick_prev;
    wire step = mode.enable && tick_edge &&
        prescale == `WWT_PRESCALE_LAST;
    wire [23:0] count_dec = count - 24'h000001;
    // Expire on the step out of zero: period is (timeout + 1) * 4 ticks
    wire expire = step && count == 24'h000000;
    wire warn_hit = step && mode.warn_en && count_dec == warn_val &&
        !expire;

    wire fault = feed_bad || window_bad;
    wire fire_reset = expire || (fault && mode.reset_en);
    wire fire_int = fault && !mode.reset_en;
    wire enable_set = wr_fire && sel_mode && mode_merged[0];
    wire enable_clr = fire_reset || fire_int;

    wire [23:0] timeout_clamped = timeout_merged[23:0] < `WWT_TIMEOUT_MIN ?
        `WWT_TIMEOUT_MIN : timeout_merged[23:0];

    wire [`WWT_EV_N-1:0] events;
    assign events[`WWT_EV_TIMEOUT] = expire;
    assign events[`WWT_EV_WARN] = warn_hit;
    assign events[`WWT_EV_FEED] = feed_bad;
    assign events[`WWT_EV_WINDOW] = window_bad;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    wwt_pkg::wwt_mode_t next_mode;
    always_comb begin
        next_mode = mode;
        if (wr_fire && sel_mode) begin
            next_mode.reset_en = mode_merged[1];
            next_mode.window_en = mode_merged[2];
            next_mode.warn_en = mode_merged[3];
            next_mode.clk_sel = mode_merged[4];
            next_mode.keep_in_deep_sleep = mode_merged[5];
        end
        // Software can only set the enable
        if (enable_clr) begin
            next_mode.enable = 1'b0;
        end else if (enable_set) begin
            next_mode.enable = 1'b1;
        end
        next_mode.unused = 26'h0000000;
    end

    logic [23:0] next_count;
    always_comb begin
        next_count = count;
        if (!mode.enable) begin
            next_count = timeout_val;
        end else if (feed_ok && !window_bad) begin
            next_count = timeout_val;
        end else if (step && !expire) begin
            next_count = count_dec;
        end else if (expire) begin
            next_count = timeout_val;
        end
    end

    wire [`WWT_EV_N-1:0] status_clr = (wr_fire && sel_status) ?
        w1c_bits[`WWT_EV_N-1:0] : {`WWT_EV_N{1'b0}};

    // ------------------------------------------------------------
    // Watchdog registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= '0;
            timeout_val <= `WWT_TIMEOUT_RST;
            window_val <= `WWT_WINDOW_RST;
            warn_val <= `WWT_WARN_RST;
            int_mask <= '0;
            count <= `WWT_TIMEOUT_RST;
            prescale <= 2'h0;
            tick_prev <= 1'b0;
            feed_state <= wwt_pkg::WWT_FEED_IDLE;
        end else begin
            mode <= next_mode;
            count <= next_count;
            tick_prev <= watchdog_tick_clock;
            if (!mode.enable || feed_ok) begin
                prescale <= 2'h0;
            end else if (tick_edge) begin
                prescale <= prescale + 2'h1;
            end
            if (wr_fire && sel_timeout) begin
                timeout_val <= timeout_clamped;
            end
            if (wr_fire && sel_window) begin
                window_val <= window_merged[23:0];
            end
            if (wr_fire && sel_warn) begin
                warn_val <= warn_merged[23:0];
            end
            if (wr_fire && sel_mask) begin
                int_mask <= mask_merged[`WWT_EV_N-1:0];
            end
            if (feed_wr && !armed && key1) begin
                feed_state <= wwt_pkg::WWT_FEED_ARMED;
            end else if (wr_fire || !mode.enable) begin
                feed_state <= wwt_pkg::WWT_FEED_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status, interrupt and reset outputs
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < `WWT_EV_N; i++) begin : g_status
            // Set wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (rst) begin
                    int_status[i] <= 1'b0;
                end else if (events[i]) begin
                    int_status[i] <= 1'b1;
                end else if (status_clr[i]) begin
                    int_status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            chip_reset <= 1'b0;
            irq <= 1'b0;
            reset_flag <= 1'b0;
            lowpower_osc_keep <= 1'b0;
        end else begin
            chip_reset <= fire_reset;
            irq <= |(int_status & int_mask);
            lowpower_osc_keep <= mode.keep_in_deep_sleep;
            if (fire_reset) begin
                reset_flag <= 1'b1;
            end else if (wr_fire && sel_flag && w1c_bits[0]) begin
                reset_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WWT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_addr <= {s_axi_awaddr[7:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
    wire [31:0] rd_mux =
        rd_addr == `WWT_OFF_MODE ? 32'(mode) :
        rd_addr == `WWT_OFF_TIMEOUT ? {8'h00, timeout_val} :
        rd_addr == `WWT_OFF_COUNT ? {8'h00, count} :
        rd_addr == `WWT_OFF_WINDOW ? {8'h00, window_val} :
        rd_addr == `WWT_OFF_WARN ? {8'h00, warn_val} :
        rd_addr == `WWT_OFF_INT_STATUS ? {28'h0000000, int_status} :
        rd_addr == `WWT_OFF_INT_MASK ? {28'h0000000, int_mask} :
        rd_addr == `WWT_OFF_RESET_FLAG ? {31'h00000000, reset_flag} :
        32'h00000000;
    wire rd_mapped = rd_addr == `WWT_OFF_FEED ||
        rd_addr == `WWT_OFF_MODE || rd_addr == `WWT_OFF_TIMEOUT ||
        rd_addr == `WWT_OFF_COUNT || rd_addr == `WWT_OFF_WINDOW ||
        rd_addr == `WWT_OFF_WARN || rd_addr == `WWT_OFF_INT_STATUS ||
        rd_addr == `WWT_OFF_INT_MASK || rd_addr == `WWT_OFF_RESET_FLAG;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `WWT_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_mapped ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // wwt_windowed_watchdog

// ===== dv/wwt_windowed_watchdog_properties.sv
// Port checker of the windowed watchdog and its bind
`timescale 1ns/1ns
module wwt_windowed_watchdog_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Chip side
    input wire logic chip_reset,
    input wire logic irq,
    input wire logic lowpower_osc_keep,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    reset_quiet_a: assert property (disable iff (1'b0) $fell(rst) |->
        !chip_reset && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    reset_pulse_a: assert property (chip_reset |=> !chip_reset [*3])
        else $error("chip reset longer than one cycle");
    write_answer_a: assert property (wr_taken |=> wr_answer)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    error_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0)
        else $error("error read carries data");
    keep_follow_a: assert property ($changed(lowpower_osc_keep) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("keep output moved without a write");
endmodule // wwt_windowed_watchdog_properties

bind wwt_windowed_watchdog wwt_windowed_watchdog_properties i_props (
    .clk, .rst, .chip_reset, .irq, .lowpower_osc_keep, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== dv/wwt_windowed_watchdog_timer_bench.sv
// Self-checking register-level bench of the windowed watchdog
`timescale 1ns/1ns
`include "wwt_defines.svh"
module wwt_windowed_watchdog_timer_bench;
    logic clk = 0, rst = 1, rc_osc = 0, lp_osc = 0, deep = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic chip_reset, irq, keep, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    int n_fail = 0, n_tests = 0, cycles = 0, n_rst = 0;
    logic [7:0] ra [8] = '{`WWT_OFF_MODE, `WWT_OFF_TIMEOUT, `WWT_OFF_COUNT,
        `WWT_OFF_WINDOW, `WWT_OFF_WARN, `WWT_OFF_INT_STATUS,
        `WWT_OFF_INT_MASK, `WWT_OFF_RESET_FLAG};
    logic [31:0] rv [8] = '{0, 32'hffffff, 32'hffffff, 32'hffffff, 0, 0, 0, 0};

    always #4 clk = ~clk;

    wwt_windowed_watchdog i_dut (.clk(clk), .rst(rst),
        .internal_rc_osc(rc_osc), .dedicated_lowpower_osc(lp_osc),
        .deep_sleep(deep), .chip_reset(chip_reset), .irq(irq),
        .lowpower_osc_keep(keep), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
        @(posedge clk);
        awvalid <= 0; wvalid <= 0;
        do @(negedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge clk);
        bready <= 0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata; rs = rresp;
        @(posedge clk);
        rready <= 0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        rd_reg(a);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task feed(input logic [31:0] second);
        wr(`WWT_OFF_FEED, 32'haa);
        wr(`WWT_OFF_FEED, second);
    endtask
    task tick(input int n, input bit lp);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (lp) lp_osc <= 1; else rc_osc <= 1;
            repeat (2) @(posedge clk);
            lp_osc <= 0; rc_osc <= 0;
            @(posedge clk);
        end
    endtask
    task ichk(input logic e);
        @(negedge clk);
        chk("irq", e, irq);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (chip_reset === 1'b1) n_rst <= n_rst + 1;
        if (cycles == 30000) begin
            n_fail++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        foreach (ra[i]) rchk(ra[i], rv[i]);
        rd_reg(8'h24);
        chk("unmapped data", 0, rd);
        chk("unmapped read resp", `WWT_RESP_SLVERR, rs);
        wr(8'h24, 32'h1);
        chk("unmapped write resp", `WWT_RESP_SLVERR, rs);
        wr(`WWT_OFF_TIMEOUT, 32'h10);
        rchk(`WWT_OFF_TIMEOUT, 32'hff);
        wr(`WWT_OFF_MODE, 32'h3);
        wr(`WWT_OFF_MODE, 32'h2);
        rchk(`WWT_OFF_MODE, 32'h3);
        feed(32'h55);
        tick(4, 0);
        rchk(`WWT_OFF_COUNT, 32'hfe);
        tick(4, 1);
        rchk(`WWT_OFF_COUNT, 32'hfe);
        feed(32'h55);
        rchk(`WWT_OFF_COUNT, 32'hff);
        tick(1023, 0);
        rchk(`WWT_OFF_COUNT, 32'h0);
        chk("resets early", 0, n_rst);
        tick(1, 0);
        chk("resets at expiry", 1, n_rst);
        rchk(`WWT_OFF_RESET_FLAG, 32'h1);
        rchk(`WWT_OFF_MODE, 32'h2);
        rchk(`WWT_OFF_INT_STATUS, 32'h1);
        wr(`WWT_OFF_INT_MASK, 32'hf);
        ichk(1);
        wr(`WWT_OFF_INT_MASK, 32'h0);
        ichk(0);
        wr(`WWT_OFF_INT_MASK, 32'hf);
        wr(`WWT_OFF_INT_STATUS, 32'h1);
        ichk(0);
        wr(`WWT_OFF_RESET_FLAG, 32'h1);
        rchk(`WWT_OFF_RESET_FLAG, 32'h0);
        wr(`WWT_OFF_MODE, 32'h31);
        @(posedge clk) deep <= 1;
        chk("keep", 1, keep);
        feed(32'h55);
        tick(4, 1);
        rchk(`WWT_OFF_COUNT, 32'hfe);
        tick(4, 0);
        rchk(`WWT_OFF_COUNT, 32'hfe);
        feed(32'h12);
        chk("resets in interrupt mode", 1, n_rst);
        rchk(`WWT_OFF_INT_STATUS, 32'h4);
        ichk(1);
        rchk(`WWT_OFF_MODE, 32'h30);
        @(posedge clk) deep <= 0;
        wr(`WWT_OFF_INT_STATUS, 32'hf);
        wr(`WWT_OFF_MODE, 32'h3);
        wr(`WWT_OFF_FEED, 32'haa);
        wr(`WWT_OFF_INT_MASK, 32'hf);
        rchk(`WWT_OFF_INT_STATUS, 32'h4);
        chk("resets on bad feed", 2, n_rst);
        wr(`WWT_OFF_INT_STATUS, 32'hf);
        wr(`WWT_OFF_WINDOW, 32'hfe);
        wr(`WWT_OFF_WARN, 32'hfe);
        wr(`WWT_OFF_MODE, 32'hd);
        feed(32'h55);
        rchk(`WWT_OFF_INT_STATUS, 32'h8);
        rchk(`WWT_OFF_MODE, 32'hc);
        wr(`WWT_OFF_INT_STATUS, 32'hf);
        wr(`WWT_OFF_MODE, 32'hd);
        tick(9, 0);
        rchk(`WWT_OFF_INT_STATUS, 32'h2);
        feed(32'h55);
        rchk(`WWT_OFF_INT_STATUS, 32'h2);
        rchk(`WWT_OFF_COUNT, 32'hff);
        close_out();
    end
endmodule // wwt_windowed_watchdog_timer_bench
